//--- hw/scc_clock_ctrl.sv
// The placing of the registers and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ns
// How it works
// [RULE1] Subclock held off through and after reset
// [RULE2] Subclock runs when pin select 1, stop 0
// [RULE3] Subclock select 1 makes subclock CPU source
// [RULE4] External subclock still needs pin select 1
// [RULE5] Feedback resistor by bit, off in stop
// [RULE6] Stop mode halts all sources and clocks except the protected watchdog clock
// [RULE7] System mux: main, subclock or on-chip
// [RULE8] Div8 bit wins, else field 1/2/4/16
// [RULE9] Reset runs CPU from low-speed, undivided
// [RULE10] Stop entry forces divide-by-8 bit to 1
// [RULE11] Software clears divider enable before stop
// [RULE12] Taps divide system clock 1,2,4,8,32
// [RULE13] Peripheral stop bit gates taps in wait
// [RULE14] On-chip peripheral clock follows on-chip clock
// [RULE15] Undivided high-speed clock when enabled only
// [RULE16] High-speed clock divided 2..9 when enabled
// [RULE17] Detector clock while low-speed oscillator on
// [RULE18] Divide-by-128 from detector or divided clock
// [RULE19] Watchdog clock under protection never stops
// [RULE20] Mode bits decode the three run modes
// [RULE21] Peripheral on-chip clock if either oscillator on
// [RULE22] Software switches only to settled sources
// [RULE23] Oscillator select picks main or on-chip
// [RULE24] Source select picks high or low on-chip
// [RULE25] Source and ratio changes are glitch free; the on-chip high/low select switches at once, without waiting for low clocks
// [RULE26] Reset selects low-speed, undivided, others off
module scc_clock_ctrl
	import scc_pkg::*;
(
	// AHB-Lite slave
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Oscillator clocks arriving from the analog cells
	input wire logic main_clk_in,
	input wire logic subclock_input,
	input wire logic losc_clk_in,
	input wire logic hosc_clk_in,
	// Power events from the CPU and wake logic
	input wire logic wait_instr,
	input wire logic wake_req,
	// Clocks and oscillator controls
	output scc_clk_t clk_out,
	output scc_osc_t osc_ctrl,
	output logic wait_mode,
	output logic stop_mode
);

	logic [7:0] ctrl0_r, ctrl1_r, ctrl3_r, oscsel_r, osc0_r, hsdiv_r, csp_r;
	logic wr_pend_r;
	logic [4:0] wr_addr_r;
	logic [31:0] hrdata_r;
	logic [7:0] rd_mux;
	logic addr_ok;
	logic [7:0] wd;
	scc_pmode_t pmode_r;
	scc_src_t src_r, src_want;
	logic stop_enter;

	// Bus: zero wait state, always OKAY
	assign addr_ok = hsel & htrans[1] & hready;
	assign wd = hwdata[7:0];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 5'h00;
		end else begin
			wr_pend_r <= addr_ok & hwrite;
			wr_addr_r <= haddr[4:0];
		end
	end

	always_comb begin
		case (haddr[4:0])
			SCC_OFF_CTRL0: rd_mux = ctrl0_r;
			SCC_OFF_CTRL1: rd_mux = ctrl1_r;
			SCC_OFF_CTRL3: rd_mux = ctrl3_r;
			SCC_OFF_OSCSEL: rd_mux = oscsel_r;
			SCC_OFF_OSC0: rd_mux = osc0_r;
			SCC_OFF_HSDIV: rd_mux = hsdiv_r;
			SCC_OFF_CSP: rd_mux = csp_r;
			SCC_OFF_STATUS: rd_mux = {3'b000, src_r, stop_mode, wait_mode};
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_r <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hrdata_r <= (addr_ok & ~hwrite) ? {24'h00_0000, rd_mux} :
				32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end
	assign hrdata = hrdata_r;

	// Control registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl0_r <= SCC_RST_CTRL0; // [RULE1] [RULE26]
		end else begin
			if (wr_pend_r && wr_addr_r == SCC_OFF_CTRL0)
				ctrl0_r <= wd;
			if (stop_enter)
				ctrl0_r[SCC_B_DIV8] <= 1'b1; // [RULE10]
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl1_r <= SCC_RST_CTRL1;
			oscsel_r <= SCC_RST_OSCSEL; // [RULE9]
			osc0_r <= SCC_RST_OSC0;
			hsdiv_r <= SCC_RST_HSDIV;
		end else if (wr_pend_r) begin
			if (wr_addr_r == SCC_OFF_CTRL1)
				ctrl1_r <= wd;
			if (wr_addr_r == SCC_OFF_OSCSEL)
				oscsel_r <= wd;
			if (wr_addr_r == SCC_OFF_OSC0)
				osc0_r <= wd;
			if (wr_addr_r == SCC_OFF_HSDIV)
				hsdiv_r <= wd;
		end
	end

	// Wait and stop requests read back as zero after one cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl3_r <= SCC_RST_CTRL3;
		end else if (wr_pend_r && wr_addr_r == SCC_OFF_CTRL3) begin
			ctrl3_r <= wd;
		end else begin
			ctrl3_r[SCC_B_WAITREQ] <= 1'b0;
			ctrl3_r[SCC_B_STOPREQ] <= 1'b0;
		end
	end

	// Protection can only be set; reset clears it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			csp_r <= SCC_RST_CSP;
		else if (wr_pend_r && wr_addr_r == SCC_OFF_CSP)
			csp_r[SCC_B_CSPEN] <= csp_r[SCC_B_CSPEN] | wd[SCC_B_CSPEN]; // [RULE19]
	end

	// Power mode
	assign stop_enter = (pmode_r == SCC_PM_RUN) & ctrl3_r[SCC_B_STOPREQ];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pmode_r <= SCC_PM_RUN;
		end else begin
			case (pmode_r)
				SCC_PM_RUN: begin
					if (ctrl3_r[SCC_B_STOPREQ])
						pmode_r <= SCC_PM_STOP;
					else if (ctrl3_r[SCC_B_WAITREQ] | wait_instr)
						pmode_r <= SCC_PM_WAIT;
				end
				SCC_PM_WAIT, SCC_PM_STOP: begin
					if (wake_req)
						pmode_r <= SCC_PM_RUN;
				end
				default: pmode_r <= SCC_PM_RUN;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wait_mode <= 1'b0;
			stop_mode <= 1'b0;
		end else begin
			wait_mode <= (pmode_r == SCC_PM_WAIT);
			stop_mode <= (pmode_r == SCC_PM_STOP);
		end
	end

	// Oscillator enables
	logic main_on, sub_on, losc_on, hosc_on, wdt_on;
	assign main_on = ctrl1_r[SCC_B_MAINPIN] & ~ctrl0_r[SCC_B_MAINSTOP] &
		~stop_mode; // [RULE6]
	assign sub_on = ctrl0_r[SCC_B_SUBPIN] & ~ctrl0_r[SCC_B_SUBSTOP] &
		~stop_mode; // [RULE2] [RULE4] [RULE6]
	assign losc_on = ~ctrl1_r[SCC_B_LOSCN] & ~stop_mode; // [RULE17]
	assign hosc_on = osc0_r[SCC_B_HSEN] & ~stop_mode; // [RULE15]
	assign wdt_on = csp_r[SCC_B_CSPEN]; // [RULE19]

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			osc_ctrl <= '0;
		end else begin
			osc_ctrl.main_osc_en <= main_on;
			osc_ctrl.sub_osc_en <= sub_on; // [RULE1] [RULE2]
			osc_ctrl.sub_feedback_en <= ctrl0_r[SCC_B_SUBPIN] &
				~ctrl1_r[SCC_B_SUBFBDIS] & ~stop_mode; // [RULE5]
			osc_ctrl.hosc_en <= hosc_on;
			osc_ctrl.losc_en <= losc_on | wdt_on;
		end
	end

	// Two-flop synchronisers, third flop only for edge detection
	logic [3:0] raw, s1_r, s2_r, s3_r;
	assign raw = {hosc_clk_in, losc_clk_in, subclock_input, main_clk_in};

	generate
		for (genvar i = 0; i < 4; i++) begin : g_sync
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					s1_r[i] <= 1'b0;
					s2_r[i] <= 1'b0;
					s3_r[i] <= 1'b0;
				end else begin
					s1_r[i] <= raw[i];
					s2_r[i] <= s1_r[i];
					s3_r[i] <= s2_r[i];
				end
			end
		end
	endgenerate

	logic main_lv, sub_lv, losc_lv, hosc_lv, onchip_lv, use_hosc;
	assign main_lv = s2_r[SCC_I_MAIN] & main_on;
	assign sub_lv = s2_r[SCC_I_SUB] & sub_on;
	assign losc_lv = s2_r[SCC_I_LOSC] & losc_on;
	assign hosc_lv = s2_r[SCC_I_HOSC] & hosc_on;
	// Falls back to the other oscillator when the chosen one is off
	assign use_hosc = (osc0_r[SCC_B_SRCSEL] & hosc_on) | ~losc_on; // [RULE24]
	assign onchip_lv = use_hosc ? hosc_lv : losc_lv; // [RULE24]

	// System clock source; switches only while both clocks are low
	logic sys_clk_r, sys_d_r, want_lv, cur_lv;

	always_comb begin
		if (ctrl0_r[SCC_B_SUBCPU])
			src_want = SCC_SRC_SUB; // [RULE3] [RULE20]
		else if (oscsel_r[SCC_B_OSCSEL])
			src_want = SCC_SRC_ONCHIP; // [RULE23] [RULE20]
		else
			src_want = SCC_SRC_MAIN; // [RULE23] [RULE20]
	end

	always_comb begin
		case (src_want)
			SCC_SRC_MAIN: want_lv = main_lv;
			SCC_SRC_SUB: want_lv = sub_lv;
			SCC_SRC_ONCHIP: want_lv = onchip_lv;
			default: want_lv = 1'b0;
		endcase
		case (src_r)
			SCC_SRC_MAIN: cur_lv = main_lv; // [RULE7]
			SCC_SRC_SUB: cur_lv = sub_lv; // [RULE7]
			SCC_SRC_ONCHIP: cur_lv = onchip_lv; // [RULE7]
			default: cur_lv = 1'b0;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			src_r <= SCC_SRC_ONCHIP; // [RULE9]
			sys_clk_r <= 1'b0;
			sys_d_r <= 1'b0;
		end else begin
			if (src_r != src_want && !sys_clk_r && !want_lv) begin
				src_r <= src_want; // [RULE25]
				sys_clk_r <= 1'b0;
			end else begin
				sys_clk_r <= cur_lv;
			end
			sys_d_r <= sys_clk_r;
		end
	end

	// CPU divider; new ratio taken only at an output toggle
	logic [4:0] cpu_ratio, cpu_act_r, cpu_cnt_r;
	logic cpu_clk_r, sys_edge;
	assign sys_edge = sys_clk_r ^ sys_d_r;

	always_comb begin
		if (ctrl0_r[SCC_B_DIV8]) begin
			cpu_ratio = SCC_EDGES_DIV8; // [RULE8]
		end else begin
			case ({ctrl1_r[SCC_B_DIVHI], ctrl1_r[SCC_B_DIVLO]})
				2'b00: cpu_ratio = SCC_EDGES_DIV1; // [RULE8]
				2'b01: cpu_ratio = SCC_EDGES_DIV2;
				2'b10: cpu_ratio = SCC_EDGES_DIV4;
				2'b11: cpu_ratio = SCC_EDGES_DIV16;
				default: cpu_ratio = SCC_EDGES_DIV1;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cpu_act_r <= SCC_EDGES_DIV1; // [RULE9]
			cpu_cnt_r <= 5'h00;
			cpu_clk_r <= 1'b0;
		end else if (pmode_r != SCC_PM_RUN) begin
			cpu_clk_r <= 1'b0;
			cpu_cnt_r <= 5'h00;
		end else if (sys_edge) begin
			if (cpu_cnt_r == cpu_act_r - 5'h01) begin
				cpu_clk_r <= ~cpu_clk_r;
				cpu_cnt_r <= 5'h00;
				if (!ctrl3_r[SCC_B_DSE])
					cpu_act_r <= cpu_ratio; // [RULE11] [RULE25]
			end else begin
				cpu_cnt_r <= cpu_cnt_r + 5'h01;
			end
		end
	end

	// Peripheral taps
	logic [4:0] tap_cnt_r, tap_src, taps_r;
	logic pstop;
	assign tap_src = {tap_cnt_r[4], tap_cnt_r[2:0], sys_clk_r}; // [RULE12]
	assign pstop = (wait_mode & ctrl0_r[SCC_B_PSTOP]) | stop_mode; // [RULE13]

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			tap_cnt_r <= 5'h00;
		else if (sys_clk_r & ~sys_d_r)
			tap_cnt_r <= tap_cnt_r + 5'h01; // [RULE12]
	end

	generate
		for (genvar t = 0; t < 5; t++) begin : g_tap
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn)
					taps_r[t] <= 1'b0;
				else
					taps_r[t] <= tap_src[t] & ~pstop; // [RULE13]
			end
		end
	endgenerate

	// High-speed divider 2..9
	logic [3:0] hdiv_cnt_r, hdiv_act_r, hdiv_want;
	logic hdiv_clk_r, hedge;
	assign hedge = (s2_r[SCC_I_HOSC] ^ s3_r[SCC_I_HOSC]) & hosc_on;
	assign hdiv_want = {1'b0, hsdiv_r[SCC_HSDIV_W-1:0]} + SCC_HSDIV_MIN;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hdiv_cnt_r <= 4'h0;
			hdiv_act_r <= SCC_HSDIV_MIN;
			hdiv_clk_r <= 1'b0;
		end else if (!hosc_on) begin
			hdiv_cnt_r <= 4'h0;
			hdiv_clk_r <= 1'b0; // [RULE16]
		end else if (hedge) begin
			if (hdiv_cnt_r == hdiv_act_r - 4'h1) begin
				hdiv_clk_r <= ~hdiv_clk_r; // [RULE16]
				hdiv_cnt_r <= 4'h0;
				hdiv_act_r <= hdiv_want;
			end else begin
				hdiv_cnt_r <= hdiv_cnt_r + 4'h1;
			end
		end
	end

	// Plain derived clocks, unaffected by wait mode
	logic onchip_r, hs_undiv_r, ls_det_r, wdt_r, sub_tap_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			onchip_r <= 1'b0;
			hs_undiv_r <= 1'b0;
			ls_det_r <= 1'b0;
			wdt_r <= 1'b0;
			sub_tap_r <= 1'b0;
		end else begin
			onchip_r <= onchip_lv & (losc_on | hosc_on); // [RULE14] [RULE21]
			hs_undiv_r <= hosc_lv; // [RULE15]
			ls_det_r <= losc_lv; // [RULE17]
			wdt_r <= s2_r[SCC_I_LOSC] & wdt_on; // [RULE19]
			sub_tap_r <= sub_lv;
		end
	end

	// Divide-by-128
	logic d128_lv, d128_d_r, d128_clk_r;
	logic [6:0] d128_cnt_r;
	assign d128_lv = osc0_r[SCC_B_D128SEL] ? hdiv_clk_r : ls_det_r; // [RULE18]

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			d128_d_r <= 1'b0;
			d128_cnt_r <= 7'h00;
			d128_clk_r <= 1'b0;
		end else begin
			d128_d_r <= d128_lv;
			if (stop_mode) begin
				d128_cnt_r <= 7'h00;
				d128_clk_r <= 1'b0; // [RULE6]
			end else if (d128_lv ^ d128_d_r) begin
				if (d128_cnt_r == SCC_D128_LAST) begin
					d128_clk_r <= ~d128_clk_r; // [RULE18]
					d128_cnt_r <= 7'h00;
				end else begin
					d128_cnt_r <= d128_cnt_r + 7'h01;
				end
			end
		end
	end

	assign clk_out = {cpu_clk_r, taps_r, onchip_r, hs_undiv_r, hdiv_clk_r,
		ls_det_r, d128_clk_r, wdt_r, sub_tap_r};

endmodule // scc_clock_ctrl

//--- pkg/scc_pkg.sv
package scc_pkg;

	// Register byte offsets
	localparam logic [4:0] SCC_OFF_CTRL0 = 5'h00;
	localparam logic [4:0] SCC_OFF_CTRL1 = 5'h04;
	localparam logic [4:0] SCC_OFF_CTRL3 = 5'h08;
	localparam logic [4:0] SCC_OFF_OSCSEL = 5'h0C;
	localparam logic [4:0] SCC_OFF_OSC0 = 5'h10;
	localparam logic [4:0] SCC_OFF_HSDIV = 5'h14;
	localparam logic [4:0] SCC_OFF_CSP = 5'h18;
	localparam logic [4:0] SCC_OFF_STATUS = 5'h1C;

	// Reset values
	localparam logic [7:0] SCC_RST_CTRL0 = 8'h28;
	localparam logic [7:0] SCC_RST_CTRL1 = 8'h00;
	localparam logic [7:0] SCC_RST_CTRL3 = 8'h00;
	localparam logic [7:0] SCC_RST_OSCSEL = 8'h04;
	localparam logic [7:0] SCC_RST_OSC0 = 8'h00;
	localparam logic [7:0] SCC_RST_HSDIV = 8'h00;
	localparam logic [7:0] SCC_RST_CSP = 8'h00;

	// Field positions, system_clock_control_0
	localparam int SCC_B_PSTOP = 2;
	localparam int SCC_B_SUBSTOP = 3;
	localparam int SCC_B_SUBPIN = 4;
	localparam int SCC_B_MAINSTOP = 5;
	localparam int SCC_B_DIV8 = 6;
	localparam int SCC_B_SUBCPU = 7;
	// system_clock_control_1
	localparam int SCC_B_SUBFBDIS = 2;
	localparam int SCC_B_MAINPIN = 3;
	localparam int SCC_B_LOSCN = 4;
	localparam int SCC_B_DIVLO = 6;
	localparam int SCC_B_DIVHI = 7;
	// system_clock_control_3
	localparam int SCC_B_WAITREQ = 0;
	localparam int SCC_B_STOPREQ = 1;
	localparam int SCC_B_DSE = 5;
	// osc_stop_detect_control
	localparam int SCC_B_OSCSEL = 2;
	// onchip_osc_control_0
	localparam int SCC_B_HSEN = 0;
	localparam int SCC_B_SRCSEL = 1;
	localparam int SCC_B_D128SEL = 3;
	// count_source_protect_register
	localparam int SCC_B_CSPEN = 7;
	localparam int SCC_HSDIV_W = 3;

	// Counts of source edges (both edges) per output half period
	localparam logic [4:0] SCC_EDGES_DIV1 = 5'h01;
	localparam logic [4:0] SCC_EDGES_DIV2 = 5'h02;
	localparam logic [4:0] SCC_EDGES_DIV4 = 5'h04;
	localparam logic [4:0] SCC_EDGES_DIV8 = 5'h08;
	localparam logic [4:0] SCC_EDGES_DIV16 = 5'h10;
	localparam logic [3:0] SCC_HSDIV_MIN = 4'h2;
	localparam logic [6:0] SCC_D128_LAST = 7'h7F;

	// Synchronised source indices
	localparam int SCC_I_MAIN = 0;
	localparam int SCC_I_SUB = 1;
	localparam int SCC_I_LOSC = 2;
	localparam int SCC_I_HOSC = 3;

	typedef enum logic [2:0] {
		SCC_SRC_MAIN = 3'b001,
		SCC_SRC_SUB = 3'b010,
		SCC_SRC_ONCHIP = 3'b100
	} scc_src_t;

	typedef enum logic [2:0] {
		SCC_PM_RUN = 3'b001,
		SCC_PM_WAIT = 3'b010,
		SCC_PM_STOP = 3'b100
	} scc_pmode_t;

	typedef struct packed {
		logic cpu;
		logic [4:0] ftap;
		logic onchip_periph_clock;
		logic highspeed_undivided_clock;
		logic highspeed_divided_clock;
		logic lowspeed_detector_clock;
		logic slow_capture_clock;
		logic watchdog_lowspeed_clock;
		logic subclock_tap;
	} scc_clk_t;

	typedef struct packed {
		logic main_osc_en;
		logic sub_osc_en;
		logic sub_feedback_en;
		logic hosc_en;
		logic losc_en;
	} scc_osc_t;

endpackage

//--- bench/scc_clock_ctrl_sva.sv
`timescale 1ns/1ns
module scc_chk
	import scc_pkg::*;
(
	// Bus
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Sources and power events
	input wire logic main_clk_in,
	input wire logic subclock_input,
	input wire logic losc_clk_in,
	input wire logic hosc_clk_in,
	input wire logic wait_instr,
	input wire logic wake_req,
	// Clock tree
	input wire scc_clk_t clk_out,
	input wire scc_osc_t osc_ctrl,
	input wire logic wait_mode,
	input wire logic stop_mode
);
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	AST_RST_SUB: assert property (
		$rose(hresetn) |-> !osc_ctrl.sub_osc_en [*2])
		else $error("subclock enabled right after reset");
	AST_RST_LOSC: assert property (
		$rose(hresetn) |-> ##1 osc_ctrl.losc_en && !osc_ctrl.main_osc_en
			&& !osc_ctrl.hosc_en)
		else $error("wrong oscillators after reset");
	AST_STOP_OSC: assert property (
		stop_mode [*2] |-> !osc_ctrl.sub_osc_en && !osc_ctrl.main_osc_en
			&& !osc_ctrl.hosc_en)
		else $error("oscillator running in stop");
	AST_STOP_FB: assert property (
		stop_mode [*2] |-> !osc_ctrl.sub_feedback_en)
		else $error("feedback connected in stop");
	AST_STOP_CLK: assert property (
		stop_mode [*6] |-> !clk_out.cpu && clk_out.ftap == 5'h0
			&& !clk_out.subclock_tap && !clk_out.onchip_periph_clock)
		else $error("clock running in stop");
	AST_HSU_GATE: assert property (
		!osc_ctrl.hosc_en [*8] |-> !clk_out.highspeed_undivided_clock)
		else $error("undivided clock without enable");
	AST_HSD_GATE: assert property (
		!osc_ctrl.hosc_en [*8] |-> !clk_out.highspeed_divided_clock)
		else $error("divided clock without enable");
	AST_DET_GATE: assert property (
		!osc_ctrl.losc_en [*8] |-> !clk_out.lowspeed_detector_clock)
		else $error("detector clock without oscillator");
	AST_SUB_GATE: assert property (
		!osc_ctrl.sub_osc_en [*8] |-> !clk_out.subclock_tap)
		else $error("subclock tap without oscillator");

	// Zero wait states and an OKAY response on every cycle
	AST_BUS_OKAY: assert property (
		hreadyout && !hresp)
		else $error("bus answered with wait or error");

	COV_WAIT: cover property ($rose(wait_mode));
	COV_STOP: cover property ($rose(stop_mode));
	COV_SUB: cover property ($rose(clk_out.subclock_tap));
endmodule // scc_chk

bind scc_clock_ctrl scc_chk scc_chk_inst(.hclk, .hresetn, .hsel, .haddr,
	.htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
	.main_clk_in, .subclock_input, .losc_clk_in, .hosc_clk_in, .wait_instr,
	.wake_req, .clk_out, .osc_ctrl, .wait_mode, .stop_mode);

//--- bench/scc_clock_ctrl_test.sv
`timescale 1ns/1ns
module scc_clock_ctrl_test
	import scc_pkg::*;
;
	localparam int W = 1600;
	localparam int K_CPU = 12;
	localparam int K_F1 = 7;
	localparam int K_OCP = 6;
	localparam int K_HSU = 5;
	localparam int K_HSD = 4;
	localparam int K_DET = 3;
	localparam int K_SLOW = 2;
	localparam int K_WDT = 1;
	localparam int K_SUB = 0;
	logic hclk, hresetn, hsel, hwrite, wait_instr, wake_req;
	logic main_clk_in, subclock_input, losc_clk_in, hosc_clk_in;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hreadyout, hresp, wait_mode, stop_mode;
	scc_clk_t clk_out;
	scc_osc_t osc_ctrl;
	logic [$bits(scc_clk_t)-1:0] cv;
	int n_mismatch = 0;
	int n_tests = 0;
	int i;

	assign cv = clk_out;

	scc_clock_ctrl scc_clock_ctrl_inst(.hclk, .hresetn, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
		.hreadyout, .hresp, .main_clk_in, .subclock_input, .losc_clk_in,
		.hosc_clk_in, .wait_instr, .wake_req, .clk_out, .osc_ctrl,
		.wait_mode, .stop_mode);

	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	// Sources are offset from hclk edges so sampling never races
	initial #3 forever #160 main_clk_in = ~main_clk_in;
	initial #5 forever #280 subclock_input = ~subclock_input;
	initial #7 forever #200 losc_clk_in = ~losc_clk_in;
	initial #9 forever #120 hosc_clk_in = ~hosc_clk_in;

	task end_sim;
		$display("Mismatches %0d of %0d checks", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		#4000000;
		n_mismatch++;
		end_sim;
	end

	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {27'h000_0000, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task wr(input logic [4:0] a, input logic [7:0] d);
		bus(1'b1, a, {24'h00_0000, d});
	endtask

	task rc(input logic [4:0] a, input logic [7:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(rd, {24'h00_0000, e});
	endtask

	// Counts rises of one clock output; a period of 0 means stopped
	task meas(input int k, input int per, input int win);
		int n, e;
		logic p;
		repeat (300) @(posedge hclk);
		n = 0;
		p = cv[k];
		repeat (win) begin
			@(posedge hclk);
			if (cv[k] === 1'b1 && p === 1'b0)
				n++;
			p = cv[k];
		end
		e = (per == 0) ? 0 : win * 40 / per;
		n_tests++;
		if (n > e + 1 || n < e - 1 || (per == 0 && n != 0)) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, n, e);
		end
	endtask

	task mode(input logic w, input logic s);
		for (int j = 0; j < 20 && {wait_mode, stop_mode} !== {w, s}; j++)
			@(posedge hclk);
		chk({30'h0000_0000, wait_mode, stop_mode}, {30'h0000_0000, w, s});
	endtask

	task pw(input logic k);
		@(posedge hclk);
		wait_instr <= k;
		wake_req <= !k;
		@(posedge hclk);
		wait_instr <= 1'b0;
		wake_req <= 1'b0;
	endtask

	initial begin
		{hresetn, hsel, hwrite, wait_instr, wake_req} = 5'h00;
		{main_clk_in, subclock_input, losc_clk_in, hosc_clk_in} = 4'h0;
		haddr = 32'h0000_0000;
		hwdata = 32'h0000_0000;
		htrans = 2'b00;
		hsize = 3'b010;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		rc(SCC_OFF_CTRL0, SCC_RST_CTRL0);
		rc(SCC_OFF_CTRL1, SCC_RST_CTRL1);
		rc(SCC_OFF_CTRL3, SCC_RST_CTRL3);
		rc(SCC_OFF_OSCSEL, SCC_RST_OSCSEL);
		rc(SCC_OFF_OSC0, SCC_RST_OSC0);
		rc(SCC_OFF_HSDIV, SCC_RST_HSDIV);
		rc(SCC_OFF_CSP, SCC_RST_CSP);
		rc(SCC_OFF_STATUS, 8'h10);
		chk({28'h000_0000, osc_ctrl.main_osc_en, osc_ctrl.sub_osc_en,
			osc_ctrl.hosc_en, osc_ctrl.losc_en}, 32'h0000_0001);
		meas(K_CPU, 400, W);
		for (i = 0; i < 5; i++)
			meas(K_F1 + i, (i == 4) ? 12800 : 400 << i, W);
		for (i = 0; i < 4; i++) begin
			wr(SCC_OFF_CTRL1, {i[1:0], 6'h00});
			meas(K_CPU, (i == 3) ? 6400 : 400 << i, W);
		end
		wr(SCC_OFF_CTRL0, 8'h68);
		meas(K_CPU, 3200, W);
		wr(SCC_OFF_CTRL0, 8'h28);
		wr(SCC_OFF_CTRL1, 8'h08);
		wr(SCC_OFF_CTRL0, 8'h08);
		wr(SCC_OFF_OSCSEL, 8'h00);
		meas(K_CPU, 320, W);
		rc(SCC_OFF_STATUS, 8'h04);
		wr(SCC_OFF_OSC0, 8'h01);
		wr(SCC_OFF_CTRL1, 8'h18);
		meas(K_DET, 0, 400);
		meas(K_OCP, 240, W);
		meas(K_HSU, 240, W);
		wr(SCC_OFF_CTRL1, 8'h08);
		wr(SCC_OFF_OSC0, 8'h03);
		wr(SCC_OFF_OSCSEL, 8'h04);
		meas(K_CPU, 240, W);
		wr(SCC_OFF_HSDIV, 8'h07);
		meas(K_HSD, 2160, W);
		wr(SCC_OFF_HSDIV, 8'h00);
		meas(K_HSD, 480, W);
		wr(SCC_OFF_OSC0, 8'h0B);
		meas(K_SLOW, 61440, 8000);
		wr(SCC_OFF_OSC0, 8'h03);
		meas(K_SLOW, 51200, 8000);
		wr(SCC_OFF_CTRL0, 8'h10);
		meas(K_SUB, 560, W);
		wr(SCC_OFF_CTRL0, 8'h90);
		meas(K_CPU, 560, W);
		rc(SCC_OFF_STATUS, 8'h08);
		wr(SCC_OFF_CTRL1, 8'h0C);
		repeat (6) @(posedge hclk);
		chk({31'h0000_0000, osc_ctrl.sub_feedback_en}, 32'h0000_0000);
		wr(SCC_OFF_CTRL1, 8'h08);
		wr(SCC_OFF_CTRL0, 8'h94);
		wr(SCC_OFF_CTRL3, 8'h01);
		mode(1'b1, 1'b0);
		meas(K_F1, 0, 400);
		meas(K_OCP, 240, W);
		meas(K_HSU, 240, W);
		meas(K_DET, 400, W);
		pw(1'b0);
		mode(1'b0, 1'b0);
		wr(SCC_OFF_CTRL0, 8'h90);
		pw(1'b1);
		mode(1'b1, 1'b0);
		meas(K_F1, 560, W);
		pw(1'b0);
		mode(1'b0, 1'b0);
		wr(SCC_OFF_CSP, 8'h80);
		wr(SCC_OFF_CSP, 8'h00);
		rc(SCC_OFF_CSP, 8'h80);
		meas(K_WDT, 400, W);
		wr(SCC_OFF_CTRL3, 8'h02);
		mode(1'b0, 1'b1);
		meas(K_CPU, 0, 400);
		meas(K_SUB, 0, 400);
		meas(K_WDT, 400, W);
		pw(1'b0);
		mode(1'b0, 1'b0);
		rc(SCC_OFF_CTRL0, 8'hD0);
		end_sim;
	end
endmodule // scc_clock_ctrl_test
